// >>> dcf_params.svh
// shared constants of the dual clock fifo pair
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH
`define DCF_WIDTH       36
`define DCF_DEPTH       512
`define DCF_PRESET0     8
`define DCF_PRESET1     16
`define DCF_RESET_EDGES 3'h4
`define DCF_HALF_A      8'h02
`define DCF_HALF_B      8'h03
`define DCF_MODE_PAR    2'h0
`define DCF_MODE_PRE0   2'h1
`define DCF_MODE_PRE1   2'h2
`define DCF_MODE_SER    2'h3
`define DCF_FLAG_IDLE   1'b1
`endif

// >>> dcf_pkg.sv
// types shared by both ends of the dual clock fifo
`include "dcf_params.svh"
package dcf_pkg;
   typedef logic [`DCF_WIDTH-1:0] dcf_word_t;
   typedef enum logic [1:0] {
      MODE_PAR  = `DCF_MODE_PAR,
      MODE_PRE0 = `DCF_MODE_PRE0,
      MODE_PRE1 = `DCF_MODE_PRE1,
      MODE_SER  = `DCF_MODE_SER
   } dcf_mode_e;
   typedef enum logic [3:0] {
      PS_IDLE = 4'h1,
      PS_WAIT = 4'h2,
      PS_ACT  = 4'h4,
      PS_REL  = 4'h8
   } dcf_pstate_e;
   typedef struct packed {
      dcf_pstate_e state;
      logic        busy;
      logic        done;
      logic        wr;
      logic        mail;
      logic        selN;
      logic        qual;
      logic        dir;
      logic        mbx;
      logic        oe;
      dcf_word_t   dout;
      dcf_word_t   din;
   } dcf_port_s;
   typedef struct packed {
      logic [7:0] cnt;
      logic       clk;
      logic       rise;
      logic       fall;
   } dcf_div_s;
endpackage

// >>> dcf_link_if.sv
// pins between the fifo device end and the host end
`timescale 1ns/1ps
interface dcf_link_if;
   import dcf_pkg::*;
   logic      port_a_clock;
   logic      port_b_clock;
   logic      port_a_select_n;
   logic      port_b_select_n;
   logic      port_a_qualifier;
   logic      port_b_qualifier;
   logic      port_a_direction;
   logic      port_b_direction;
   logic      port_a_mailbox_choose;
   logic      port_b_mailbox_choose;
   logic      a_to_b_mail_flag_n;
   logic      b_to_a_mail_flag_n;
   logic      input_ready;
   logic      outputReady;
   logic      almost_empty_flag_n;
   logic      almost_full_flag_n;
   logic      rewind_to_mark;
   logic      replay_mode_request;
   logic      offset_sel1_serial_en;
   logic      offset_sel0_serial_bit;
   logic      deviceRstN;
   dcf_word_t hostADataOut;
   logic      hostADataOe;
   dcf_word_t devADataOut;
   logic      devADataOe;
   dcf_word_t hostBDataOut;
   logic      hostBDataOe;
   dcf_word_t devBDataOut;
   logic      devBDataOe;
   dcf_word_t port_a_data;
   dcf_word_t port_b_data;

   // resolved bus level; an undriven bus reads as zero
   assign port_a_data = devADataOe ? devADataOut :
                        (hostADataOe ? hostADataOut : '0);
   assign port_b_data = devBDataOe ? devBDataOut :
                        (hostBDataOe ? hostBDataOut : '0);

   modport device (
      input  port_a_clock, port_b_clock, port_a_select_n,
             port_b_select_n, port_a_qualifier, port_b_qualifier,
             port_a_direction, port_b_direction, port_a_mailbox_choose,
             port_b_mailbox_choose, rewind_to_mark, replay_mode_request,
             offset_sel1_serial_en, offset_sel0_serial_bit,
             port_a_data, port_b_data,
      output a_to_b_mail_flag_n, b_to_a_mail_flag_n, input_ready,
             outputReady, almost_empty_flag_n, almost_full_flag_n,
             devADataOut, devADataOe, devBDataOut, devBDataOe
   );
   modport host (
      output port_a_clock, port_b_clock, port_a_select_n,
             port_b_select_n, port_a_qualifier, port_b_qualifier,
             port_a_direction, port_b_direction, port_a_mailbox_choose,
             port_b_mailbox_choose, rewind_to_mark, replay_mode_request,
             offset_sel1_serial_en, offset_sel0_serial_bit, deviceRstN,
             hostADataOut, hostADataOe, hostBDataOut, hostBDataOe,
      input  a_to_b_mail_flag_n, b_to_a_mail_flag_n, input_ready,
             outputReady, almost_empty_flag_n, almost_full_flag_n,
             port_a_data, port_b_data
   );
endinterface

// >>> dcf_device_end.sv
// fifo device end: array, mailboxes, flags, offsets and retransmit
`timescale 1ns/1ps
`include "dcf_params.svh"
module dcf_device_end
   import dcf_pkg::*;
#(
   parameter int DEPTH   = `DCF_DEPTH,
   parameter int PRESET0 = `DCF_PRESET0,
   parameter int PRESET1 = `DCF_PRESET1
)(
   input  logic     clock,
   input  logic     rst_n,
   dcf_link_if.device link,
   output logic     progDone,
   output logic     replayActive
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);
   localparam logic [PW-1:0] ONE      = PW'(1);
   localparam logic [4:0]    SER_LAST = 5'(2 * AW - 1);

   typedef struct packed {
      logic [DEPTH-1:0][`DCF_WIDTH-1:0] mem;
      logic [PW-1:0] wrPtr;
      logic [PW-1:0] rdPtr;
      logic [PW-1:0] markPtr;
      dcf_word_t     outWord;
      dcf_word_t     a2bMail;
      dcf_word_t     b2aMail;
      dcf_word_t     aDataOut;
      dcf_word_t     bDataOut;
      logic          aOe;
      logic          bOe;
      logic          a2bFlagN;
      logic          b2aFlagN;
      logic          outRdy;
      logic          nonEmptyS1;
      logic          nonEmptyS2;
      logic          irS1;
      logic          inputReady;
      logic          afS1;
      logic          afN;
      logic          aeS1;
      logic          aeN;
      logic          prevA;
      logic          prevB;
      logic          latched;
      logic          progDone;
      logic          parCnt;
      dcf_mode_e     mode;
      logic [AW-1:0] aeOff;
      logic [AW-1:0] afOff;
      logic [4:0]    serCnt;
      logic          replay;
   } dcf_dev_s;

   dcf_dev_s st;
   dcf_dev_s next_st;

   logic          aRise;
   logic          bRise;
   logic          aWr;
   logic          aRd;
   logic          bWr;
   logic          bRd;
   logic [PW-1:0] memCnt;
   logic [PW-1:0] heldCnt;
   logic [PW-1:0] freeCnt;
   logic [PW-1:0] wordCnt;
   logic          rawNotFull;
   logic          rawNonEmpty;

   always_comb begin
      aRise = link.port_a_clock & ~st.prevA;
      bRise = link.port_b_clock & ~st.prevB;
      aWr = aRise & ~link.port_a_select_n & link.port_a_qualifier
            & link.port_a_direction;
      aRd = aRise & ~link.port_a_select_n & link.port_a_qualifier
            & ~link.port_a_direction;
      bWr = bRise & ~link.port_b_select_n & link.port_b_qualifier
            & ~link.port_b_direction;
      bRd = bRise & ~link.port_b_select_n & link.port_b_qualifier
            & link.port_b_direction;
      memCnt = st.wrPtr - st.rdPtr;
      // in replay the mark, not the read pointer, bounds the writer
      heldCnt = st.wrPtr - (st.replay ? st.markPtr : st.rdPtr);
      freeCnt = FULL_CNT - heldCnt;
      wordCnt = memCnt + {{(PW-1){1'b0}}, st.outRdy};
      rawNotFull = (heldCnt != FULL_CNT);
      rawNonEmpty = (memCnt != '0);

      next_st = st;
      next_st.prevA = link.port_a_clock;
      next_st.prevB = link.port_b_clock;

      // method caught once, on the first cycle after reset release
      if (!st.latched) begin
         next_st.latched = 1'b1;
         next_st.mode = dcf_mode_e'({link.offset_sel1_serial_en,
                                     link.offset_sel0_serial_bit});
         case (next_st.mode)
            MODE_PRE0: begin
               next_st.aeOff = AW'(PRESET0);
               next_st.afOff = AW'(PRESET0);
               next_st.progDone = 1'b1;
            end
            MODE_PRE1: begin
               next_st.aeOff = AW'(PRESET1);
               next_st.afOff = AW'(PRESET1);
               next_st.progDone = 1'b1;
            end
            default: next_st.progDone = 1'b0;
         endcase
      end

      if (st.latched && !st.progDone && st.mode == MODE_SER && aRise
          && !link.offset_sel1_serial_en) begin
         {next_st.afOff, next_st.aeOff} = {st.afOff[AW-2:0], st.aeOff,
                                          link.offset_sel0_serial_bit};
         next_st.serCnt = st.serCnt + 5'h01;
         if (st.serCnt == SER_LAST) begin
            next_st.progDone = 1'b1;
         end
      end

      // clears first so that a same-edge write leaves the flag low
      if (bRd && link.port_b_mailbox_choose) begin
         next_st.a2bFlagN = 1'b1;
      end
      if (aRd && link.port_a_mailbox_choose) begin
         next_st.b2aFlagN = 1'b1;
      end

      if (aWr && link.port_a_mailbox_choose) begin
         next_st.a2bMail = link.port_a_data;
         next_st.a2bFlagN = 1'b0;
      end else if (aWr && st.latched && !st.progDone
                   && st.mode == MODE_PAR) begin
         next_st.parCnt = 1'b1;
         if (!st.parCnt) begin
            next_st.aeOff = link.port_a_data[AW-1:0];
         end else begin
            next_st.afOff = link.port_a_data[AW-1:0];
            next_st.progDone = 1'b1;
         end
      end else if (aWr && st.progDone && st.inputReady && rawNotFull) begin
         next_st.mem[st.wrPtr[AW-1:0]] = link.port_a_data;
         next_st.wrPtr = st.wrPtr + ONE;
      end

      if (bWr && link.port_b_mailbox_choose) begin
         next_st.b2aMail = link.port_b_data;
         next_st.b2aFlagN = 1'b0;
      end

      if (aRise) begin
         // writes in parallel mode must reach the offsets before done
         next_st.irS1 = rawNotFull
                        & (st.progDone | st.mode == MODE_PAR);
         next_st.inputReady = st.irS1;
         next_st.afS1 = (freeCnt > PW'(st.afOff));
         next_st.afN = st.afS1;
      end

      if (bRise) begin
         next_st.nonEmptyS1 = rawNonEmpty;
         next_st.nonEmptyS2 = st.nonEmptyS1;
         next_st.aeS1 = (wordCnt > PW'(st.aeOff));
         next_st.aeN = st.aeS1;
         if (!link.replay_mode_request) begin
            next_st.replay = 1'b0;
         end else if (!st.replay && st.outRdy) begin
            next_st.replay = 1'b1;
            next_st.markPtr = st.rdPtr - ONE;
         end
      end

      if (bRise && st.replay && link.rewind_to_mark) begin
         next_st.outWord = st.mem[st.markPtr[AW-1:0]];
         next_st.rdPtr = st.markPtr + ONE;
         next_st.outRdy = 1'b1;
      end else if (bRd && !link.port_b_mailbox_choose && st.outRdy) begin
         // the next word falls through at once when one is stored
         if (rawNonEmpty) begin
            next_st.outWord = st.mem[st.rdPtr[AW-1:0]];
            next_st.rdPtr = st.rdPtr + ONE;
         end else begin
            next_st.outRdy = 1'b0;
         end
      end else if (bRise && !st.outRdy && st.nonEmptyS2 && rawNonEmpty) begin
         next_st.outWord = st.mem[st.rdPtr[AW-1:0]];
         next_st.rdPtr = st.rdPtr + ONE;
         next_st.outRdy = 1'b1;
      end

      // enables are registered, so the bus turns one cycle late
      next_st.aOe = ~link.port_a_select_n & ~link.port_a_direction;
      next_st.aDataOut = next_st.b2aMail;
      next_st.bOe = ~link.port_b_select_n & link.port_b_direction;
      next_st.bDataOut = link.port_b_mailbox_choose ? next_st.a2bMail
                                                    : next_st.outWord;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st          <= '0;
         st.a2bFlagN <= `DCF_FLAG_IDLE;
         st.b2aFlagN <= `DCF_FLAG_IDLE;
         st.afN      <= `DCF_FLAG_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign link.a_to_b_mail_flag_n  = st.a2bFlagN;
   assign link.b_to_a_mail_flag_n  = st.b2aFlagN;
   assign link.input_ready         = st.inputReady;
   assign link.outputReady         = st.outRdy;
   assign link.almost_empty_flag_n = st.aeN;
   assign link.almost_full_flag_n  = st.afN;
   assign link.devADataOut         = st.aDataOut;
   assign link.devADataOe          = st.aOe;
   assign link.devBDataOut         = st.bDataOut;
   assign link.devBDataOe          = st.bOe;
   assign progDone                 = st.progDone;
   assign replayActive             = st.replay;
endmodule

// >>> dcf_host_end.sv
// host end: port clocks, reset hold, transfers and serial offsets
`timescale 1ns/1ps
`include "dcf_params.svh"
module dcf_host_end
   import dcf_pkg::*;
#(
   parameter int         DEPTH  = `DCF_DEPTH,
   parameter logic [7:0] HALF_A = `DCF_HALF_A,
   parameter logic [7:0] HALF_B = `DCF_HALF_B,
   parameter int         SW     = 2 * $clog2(DEPTH)
)(
   input  logic          clock,
   input  logic          rst_n,
   dcf_link_if.host      link,
   input  logic [1:0]    offsetMode,
   input  logic          aReq,
   input  logic          aWrite,
   input  logic          aMail,
   input  dcf_word_t     aWrData,
   output logic          aBusy,
   output logic          aDone,
   output dcf_word_t     aRdData,
   input  logic          bReq,
   input  logic          bWrite,
   input  logic          bMail,
   input  dcf_word_t     bWrData,
   output logic          bBusy,
   output logic          bDone,
   output dcf_word_t     bRdData,
   input  logic          serialReq,
   input  logic [SW-1:0] serialWord,
   output logic          serialBusy,
   input  logic          replayReq,
   input  logic          rewindReq,
   output logic          linkReady
);
   typedef struct packed {
      dcf_div_s      divA;
      dcf_div_s      divB;
      logic [2:0]    rstA;
      logic [2:0]    rstB;
      logic          devRstN;
      dcf_port_s     pa;
      dcf_port_s     pb;
      logic [SW-1:0] serWord;
      logic [4:0]    serCnt;
      logic          serBusy;
      logic          serEnN;
      logic          serBit;
      logic          replay;
      logic          rewind;
   } dcf_host_s;

   dcf_host_s st;
   dcf_host_s next_st;

   function automatic dcf_div_s divStep(dcf_div_s d, logic [7:0] half);
      dcf_div_s n;
      n = d;
      n.rise = 1'b0;
      n.fall = 1'b0;
      if (d.cnt >= half - 8'h01) begin
         n.cnt = 8'h00;
         n.clk = ~d.clk;
         n.rise = ~d.clk;
         n.fall = d.clk;
      end else begin
         n.cnt = d.cnt + 8'h01;
      end
      return n;
   endfunction

   // wrLevel is the direction level that means write on this port
   function automatic dcf_port_s portStep(dcf_port_s p, dcf_div_s d,
      logic req, logic wr, logic mail, dcf_word_t wdata, dcf_word_t bus,
      logic wrLevel);
      dcf_port_s n;
      n = p;
      n.done = 1'b0;
      case (p.state)
         PS_IDLE: if (req) begin
            n.state = PS_WAIT;
            n.busy = 1'b1;
            n.wr = wr;
            n.mail = mail;
            n.dout = wdata;
         end
         PS_WAIT: if (d.fall) begin
            n.selN = 1'b0;
            n.qual = 1'b1;
            n.dir = p.wr ? wrLevel : ~wrLevel;
            n.mbx = p.mail;
            n.oe = p.wr;
            n.state = PS_ACT;
         end
         PS_ACT: if (d.rise) begin
            n.din = bus;
            n.state = PS_REL;
         end
         PS_REL: if (d.fall) begin
            n.selN = 1'b1;
            n.qual = 1'b0;
            n.oe = 1'b0;
            n.done = 1'b1;
            n.busy = 1'b0;
            n.state = PS_IDLE;
         end
         default: n.state = PS_IDLE;
      endcase
      return n;
   endfunction

   always_comb begin
      next_st = st;
      next_st.divA = divStep(st.divA, HALF_A);
      next_st.divB = divStep(st.divB, HALF_B);
      next_st.replay = replayReq;
      next_st.rewind = rewindReq;
      if (!st.devRstN) begin
         // method lines stand steady across the reset release
         next_st.serEnN = offsetMode[1];
         next_st.serBit = offsetMode[0];
         if (next_st.divA.rise && st.rstA != `DCF_RESET_EDGES) begin
            next_st.rstA = st.rstA + 3'h1;
         end
         if (next_st.divB.rise && st.rstB != `DCF_RESET_EDGES) begin
            next_st.rstB = st.rstB + 3'h1;
         end
         if (st.rstA == `DCF_RESET_EDGES && st.rstB == `DCF_RESET_EDGES
             && next_st.divA.fall) begin
            next_st.devRstN = 1'b1;
         end
      end else begin
         next_st.pa = portStep(st.pa, next_st.divA, aReq, aWrite, aMail,
                               aWrData, link.port_a_data, 1'b1);
         next_st.pb = portStep(st.pb, next_st.divB, bReq, bWrite, bMail,
                               bWrData, link.port_b_data, 1'b0);
         if (serialReq && !st.serBusy) begin
            next_st.serWord = serialWord;
            next_st.serCnt = 5'(SW);
            next_st.serBusy = 1'b1;
         end else if (next_st.divA.fall && st.serCnt != 5'h00) begin
            next_st.serEnN = 1'b0;
            next_st.serBit = st.serWord[SW-1];
            next_st.serWord = {st.serWord[SW-2:0], 1'b0};
            next_st.serCnt = st.serCnt - 5'h01;
         end else if (next_st.divA.fall && st.serBusy) begin
            next_st.serEnN = 1'b1;
            next_st.serBusy = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st          <= '0;
         st.pa.state <= PS_IDLE;
         st.pb.state <= PS_IDLE;
         st.pa.selN  <= 1'b1;
         st.pb.selN  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign link.port_a_clock           = st.divA.clk;
   assign link.port_b_clock           = st.divB.clk;
   assign link.deviceRstN             = st.devRstN;
   assign link.port_a_select_n        = st.pa.selN;
   assign link.port_a_qualifier       = st.pa.qual;
   assign link.port_a_direction       = st.pa.dir;
   assign link.port_a_mailbox_choose  = st.pa.mbx;
   assign link.hostADataOut           = st.pa.dout;
   assign link.hostADataOe            = st.pa.oe;
   assign link.port_b_select_n        = st.pb.selN;
   assign link.port_b_qualifier       = st.pb.qual;
   assign link.port_b_direction       = st.pb.dir;
   assign link.port_b_mailbox_choose  = st.pb.mbx;
   assign link.hostBDataOut           = st.pb.dout;
   assign link.hostBDataOe            = st.pb.oe;
   assign link.offset_sel1_serial_en  = st.serEnN;
   assign link.offset_sel0_serial_bit = st.serBit;
   assign link.replay_mode_request    = st.replay;
   assign link.rewind_to_mark         = st.rewind;
   assign aBusy                       = st.pa.busy;
   assign aDone                       = st.pa.done;
   assign aRdData                     = st.pa.din;
   assign bBusy                       = st.pb.busy;
   assign bDone                       = st.pb.done;
   assign bRdData                     = st.pb.din;
   assign serialBusy                  = st.serBusy;
   assign linkReady                   = st.devRstN;
endmodule

// >>> dcf_link_asserts.sv
// concurrent checks on the pins between the two fifo ends
`timescale 1ns/1ps
module dcf_link_asserts (
   input logic clock,
   input logic deviceRstN,
   input logic port_a_clock,
   input logic port_b_clock,
   input logic port_a_select_n,
   input logic port_b_select_n,
   input logic port_a_qualifier,
   input logic port_b_qualifier,
   input logic port_a_direction,
   input logic port_b_direction,
   input logic port_a_mailbox_choose,
   input logic port_b_mailbox_choose,
   input logic a_to_b_mail_flag_n,
   input logic b_to_a_mail_flag_n,
   input logic outputReady,
   input logic almost_empty_flag_n,
   input logic devADataOe,
   input logic devBDataOe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!deviceRstN);

   chk_a_float: assert property (
      port_a_select_n || port_a_direction |=> !devADataOe)
      else $error("port a bus driven while deselected or writing");
   chk_b_float: assert property (
      port_b_select_n || !port_b_direction |=> !devBDataOe)
      else $error("port b bus driven while deselected or writing");
   chk_ab_set: assert property (
      $rose(port_a_clock) && !port_a_select_n && port_a_qualifier
      && port_a_direction && port_a_mailbox_choose
      |-> ##[1:3] !a_to_b_mail_flag_n)
      else $error("a to b flag not lowered by mailbox write");
   chk_ab_clear: assert property (
      $rose(port_b_clock) && !port_b_select_n && port_b_qualifier
      && port_b_direction && port_b_mailbox_choose
      |-> ##[1:3] a_to_b_mail_flag_n)
      else $error("a to b flag not raised by mailbox read");
   chk_ba_set: assert property (
      $rose(port_b_clock) && !port_b_select_n && port_b_qualifier
      && !port_b_direction && port_b_mailbox_choose
      |-> ##[1:3] !b_to_a_mail_flag_n)
      else $error("b to a flag not lowered by mailbox write");
   chk_ba_clear: assert property (
      $rose(port_a_clock) && !port_a_select_n && port_a_qualifier
      && !port_a_direction && port_a_mailbox_choose
      |-> ##[1:3] b_to_a_mail_flag_n)
      else $error("b to a flag not raised by mailbox read");
   // holds only while the almost empty offset is above zero
   chk_empty_ae: assert property (
      !outputReady |-> !almost_empty_flag_n)
      else $error("almost empty high while fifo empty");
   chk_a_hold: assert property (
      $rose(port_a_clock) |-> $stable(port_a_select_n)
      && $stable(port_a_direction))
      else $error("port a control moved at its rising edge");

   cover property (!a_to_b_mail_flag_n);
   cover property (!b_to_a_mail_flag_n);
   cover property ($rose(almost_empty_flag_n));
endmodule

// >>> dual_clock_fifo_mailbox_retransmit_tb_top.sv
// self-checking bench driving both fifo ends through the host end
`timescale 1ns/1ps
module dual_clock_fifo_mailbox_retransmit_tb_top;
   import dcf_pkg::*;
   logic      clock, rst_n, linkReady, progDone, replayActive;
   logic      aReq, aWrite, aMail, aBusy, aDone;
   logic      bReq, bWrite, bMail, bBusy, bDone;
   logic      replayReq, rewindReq;
   logic [1:0] offMode = 2'h1;
   dcf_word_t aWrData, aRdData, bWrData, bRdData;
   int        num_errors, n_tests;
   int        cycles = 0;

   dcf_link_if link ();
   // preset method 01 keeps the almost empty offset at eight
   dcf_host_end i_dcf_host_end (.clock(clock), .rst_n(rst_n),
      .link(link), .offsetMode(offMode), .aReq(aReq), .aWrite(aWrite),
      .aMail(aMail), .aWrData(aWrData), .aBusy(aBusy), .aDone(aDone),
      .aRdData(aRdData), .bReq(bReq), .bWrite(bWrite), .bMail(bMail),
      .bWrData(bWrData), .bBusy(bBusy), .bDone(bDone),
      .bRdData(bRdData), .serialReq(1'b0), .serialWord('0),
      .serialBusy(), .replayReq(replayReq), .rewindReq(rewindReq),
      .linkReady(linkReady));
   dcf_device_end i_dcf_device_end (.clock(clock),
      .rst_n(link.deviceRstN), .link(link), .progDone(progDone),
      .replayActive(replayActive));
   dcf_link_asserts i_dcf_link_asserts (.clock(clock),
      .deviceRstN(link.deviceRstN), .port_a_clock(link.port_a_clock),
      .port_b_clock(link.port_b_clock),
      .port_a_select_n(link.port_a_select_n),
      .port_b_select_n(link.port_b_select_n),
      .port_a_qualifier(link.port_a_qualifier),
      .port_b_qualifier(link.port_b_qualifier),
      .port_a_direction(link.port_a_direction),
      .port_b_direction(link.port_b_direction),
      .port_a_mailbox_choose(link.port_a_mailbox_choose),
      .port_b_mailbox_choose(link.port_b_mailbox_choose),
      .a_to_b_mail_flag_n(link.a_to_b_mail_flag_n),
      .b_to_a_mail_flag_n(link.b_to_a_mail_flag_n),
      .outputReady(link.outputReady),
      .almost_empty_flag_n(link.almost_empty_flag_n),
      .devADataOe(link.devADataOe), .devBDataOe(link.devBDataOe));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         $display("mismatch at %0t: %s", $time, msg);
         num_errors++;
      end
   endtask

   function automatic dcf_word_t word(input int i);
      return 36'ha5a500000 + 36'(i);
   endfunction

   function automatic logic sig(input int s);
      case (s)
         0: return link.outputReady;
         1: return replayActive;
         2: return link.almost_empty_flag_n;
         4: return link.input_ready;
         default: return progDone;
      endcase
   endfunction

   task automatic waitSig(input int s, input logic v, input string msg);
      int i;
      for (i = 0; i < 100; i++) begin
         @(posedge clock);
         if (sig(s) === v) break;
      end
      check(sig(s) === v, msg);
   endtask

   task automatic opA(input logic w, input logic m, input dcf_word_t d);
      int i;
      @(posedge clock);
      aReq <= 1'b1;
      aWrite <= w;
      aMail <= m;
      aWrData <= d;
      @(posedge clock);
      aReq <= 1'b0;
      for (i = 0; i < 200 && aDone !== 1'b1; i++) @(posedge clock);
      check(aDone === 1'b1, "port a transfer never completed");
   endtask

   task automatic opB(input logic w, input logic m, input dcf_word_t d);
      int i;
      @(posedge clock);
      bReq <= 1'b1;
      bWrite <= w;
      bMail <= m;
      bWrData <= d;
      @(posedge clock);
      bReq <= 1'b0;
      for (i = 0; i < 200 && bDone !== 1'b1; i++) @(posedge clock);
      check(bDone === 1'b1, "port b transfer never completed");
   endtask

   task automatic mailAtoB();
      opA(1'b1, 1'b1, 36'hf0123abcd);
      check(link.a_to_b_mail_flag_n === 1'b0, "no new mail flag");
      opB(1'b0, 1'b1, '0);
      check(bRdData === 36'hf0123abcd, "mailbox word wrong");
      check(link.a_to_b_mail_flag_n === 1'b1, "flag kept");
      check(link.outputReady === 1'b0, "mail went to fifo");
   endtask

   task automatic mailBtoA();
      opB(1'b1, 1'b1, 36'h5a5a5a5a5);
      check(link.b_to_a_mail_flag_n === 1'b0, "no new mail flag");
      opA(1'b0, 1'b1, '0);
      check(aRdData === 36'h5a5a5a5a5, "mailbox word wrong");
      check(link.b_to_a_mail_flag_n === 1'b1, "flag kept");
      opB(1'b1, 1'b0, 36'h1);
      opB(1'b0, 1'b0, '0);
      check(link.outputReady === 1'b0, "port b write filled fifo");
   endtask

   task automatic fifoFlow();
      int i;
      for (i = 0; i < 10; i++) opA(1'b1, 1'b0, word(i));
      waitSig(0, 1'b1, "output ready never rose");
      waitSig(2, 1'b1, "almost empty stuck low");
      for (i = 0; i < 10; i++) begin
         opB(1'b0, 1'b0, '0);
         check(bRdData === word(i), "fifo word out of order");
         if (i == 1) waitSig(2, 1'b0, "almost empty high");
      end
      waitSig(0, 1'b0, "output ready high when empty");
   endtask

   task automatic replayRun();
      int i;
      for (i = 16; i < 19; i++) opA(1'b1, 1'b0, word(i));
      waitSig(0, 1'b1, "replay data not ready");
      replayReq <= 1'b1;
      waitSig(1, 1'b1, "replay mode not entered");
      opB(1'b0, 1'b0, '0);
      opB(1'b0, 1'b0, '0);
      check(bRdData === word(17), "second word wrong");
      rewindReq <= 1'b1;
      repeat (20) @(posedge clock);
      rewindReq <= 1'b0;
      opB(1'b0, 1'b0, '0);
      check(bRdData === word(16), "rewind missed the mark");
      replayReq <= 1'b0;
      waitSig(1, 1'b0, "replay mode kept");
      for (i = 17; i < 19; i++) begin
         opB(1'b0, 1'b0, '0);
         check(bRdData === word(i), "word lost after rewind");
      end
   endtask

   task automatic fillUp();
      int i;
      for (i = 0; i < 513; i++) begin
         opA(1'b1, 1'b0, word(i));
         if (i != 503 && i != 511) continue;
         repeat (16) @(posedge clock);
         check(link.almost_full_flag_n === (i < 504), "af wrong");
         check(link.input_ready === 1'b1, "ir low early");
      end
      waitSig(4, 1'b0, "ir high at full");
   endtask

   task automatic parLoad();
      offMode <= 2'h0;
      rst_n <= 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      repeat (40) @(posedge clock);
      opA(1'b1, 1'b0, 36'h4);
      opA(1'b1, 1'b0, 36'h1f0);
      waitSig(3, 1'b1, "no parallel load");
      repeat (30) @(posedge clock);
      check(link.outputReady === 1'b0, "offset stored");
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   initial begin
      {rst_n, aReq, aWrite, aMail, bReq, bWrite, bMail} = '0;
      {replayReq, rewindReq, aWrData, bWrData} = '0;
      num_errors = 0;
      n_tests = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      waitSig(3, 1'b1, "offsets never loaded");
      mailAtoB();
      mailBtoA();
      fifoFlow();
      replayRun();
      fillUp();
      parLoad();
      tally_and_finish();
   end
endmodule
